//--- hw/pcs_cfg.svh
// constants of the program flow and stack context unit
`ifndef PCS_CFG_SVH
`define PCS_CFG_SVH
`define PCS_VEC_TOP     20'h0fffe
`define PCS_PCNT_RST    20'h00000
`define PCS_STK_RST     20'h00000
`define PCS_STAT_RST    16'h0000
`define PCS_IDX_PROG    4'h0
`define PCS_IDX_STACK   4'h1
`define PCS_IDX_STAT    4'h2
`define PCS_IDX_CONST   4'h3
`define PCS_IDX_GPR_LO  4'h4
`define PCS_WORD_STEP   20'h00002
`endif

//--- hw/pcs_core.sv
// program counter, stack pointer, register file and context sequencer
`timescale 1ns/100ps
`include "pcs_cfg.svh"

// Function
// - vectors fetched downward from top word address
// - handler entered with upper counter bits zero
// - interrupt entry saves counter bits in status
// - interrupt exit restores status and full counter
// - sixteen registers, four dedicated, twelve general
// - counter advances by instruction length, two-eight
// - counter bit zero always reads zero
// - short jump and call clear upper bits
// - only long forms, interrupt exit and aword counter writes load bits above 64 KB
// - word write to counter clears upper bits
// - short call pushes 16 bits, long 20
// - long return reloads 20 bits, adds four
// - short return reloads 16 bits, adds two
// - stack predecrement on push, postincrement on pop
// - stack pointer bit zero held at zero
// - 20-bit address bus, 16-bit data bus
// - pop into stack pointer skips the increment
module pcs_core import pcs_pkg::*; #(
    parameter int VEC_W = 5
) (
    input  wire logic             clk_sys,         // system clock
    input  wire logic             rstn,            // async reset, active low
    input  wire logic             cmd_valid,       // command offered
    output logic                  cmd_ready,       // unit idle, command taken
    input  wire pcs_op_t          cmd_op,          // flow operation
    input  wire logic [1:0]       cmd_len,         // instruction length in words minus one
    input  wire logic [19:0]      cmd_arg,         // jump target or push data
    input  wire logic [VEC_W-1:0] cmd_vec,         // interrupt vector number
    input  wire logic [3:0]       cmd_dst,         // pop destination register
    input  wire logic             reg_wr_en,       // register write request
    input  wire logic [3:0]       reg_wr_idx,      // register written
    input  wire pcs_size_t        reg_wr_size,     // operand size of the write
    input  wire logic [19:0]      reg_wr_data,     // write data
    input  wire logic [3:0]       reg_rd_idx,      // register read
    output logic [19:0]           reg_rd_data,     // read data, one cycle later
    output logic [19:0]           program_counter, // current program counter
    output logic [19:0]           stack_pointer,   // current stack pointer
    output logic [15:0]           status_word,     // current status word
    output logic [19:0]           mem_addr,        // memory address
    output logic [15:0]           mem_wdata,       // memory write data
    output logic                  mem_rd,          // memory read request
    output logic                  mem_wr,          // memory write request
    input  wire logic             mem_ack,         // memory completes request
    input  wire logic [15:0]      mem_rdata        // memory read data
);
    pcs_state_t       state_ff, nxt_state;
    pcs_op_t          op_ff, nxt_op;
    logic [19:0]      pc_ff, nxt_pc, stk_ff, nxt_stk, arg_ff, nxt_arg;
    logic [15:0]      sr_ff, nxt_sr, hold_ff, nxt_hold;
    logic [3:0]       dst_ff, nxt_dst;
    logic [VEC_W-1:0] vec_ff, nxt_vec;
    logic [19:0]      addr_ff, nxt_addr, rd_ff, nxt_rd;
    logic [15:0]      wdata_ff, nxt_wdata;
    logic             mrd_ff, nxt_mrd, mwr_ff, nxt_mwr;
    logic             gpr_we;
    logic [3:0]       gpr_idx;
    logic [19:0]      gpr_val;
    logic [19:0]      gpr_ff [4:15];
    logic             wr_go;

    function automatic logic [19:0] sized(input logic [19:0] d, input pcs_size_t s);
        case (s)
            PCS_SZ_BYTE: sized = {12'h000, d[7:0]};
            PCS_SZ_WORD: sized = {4'h0, d[15:0]};
            default:     sized = d;
        endcase
    endfunction

    assign cmd_ready       = (state_ff == ST_IDLE);
    assign wr_go           = cmd_ready && !cmd_valid && reg_wr_en;
    assign program_counter = pc_ff;
    assign stack_pointer   = stk_ff;
    assign status_word     = sr_ff;
    assign mem_addr        = addr_ff;
    assign mem_wdata       = wdata_ff;
    assign mem_rd          = mrd_ff;
    assign mem_wr          = mwr_ff;
    assign reg_rd_data     = rd_ff;

    // sequencer: one command at a time, memory steps wait for mem_ack
    always_comb begin
        nxt_state = state_ff;
        nxt_op    = op_ff;
        nxt_pc    = pc_ff;
        nxt_stk   = stk_ff;
        nxt_sr    = sr_ff;
        nxt_arg   = arg_ff;
        nxt_dst   = dst_ff;
        nxt_vec   = vec_ff;
        nxt_hold  = hold_ff;
        gpr_we    = 1'b0;
        gpr_idx   = reg_wr_idx;
        gpr_val   = sized(reg_wr_data, reg_wr_size);
        case (state_ff)
            ST_IDLE: begin
                if (cmd_valid) begin
                    nxt_op  = cmd_op;
                    nxt_arg = cmd_arg;
                    nxt_dst = cmd_dst;
                    nxt_vec = cmd_vec;
                    case (cmd_op)
                        PCS_OP_STEP:   nxt_pc = pc_ff + 20'({cmd_len, 1'b0}) + `PCS_WORD_STEP;
                        PCS_OP_JMP_S:  nxt_pc = {4'h0, cmd_arg[15:1], 1'b0};
                        PCS_OP_JMP_L:  nxt_pc = {cmd_arg[19:1], 1'b0};
                        PCS_OP_CALL_S, PCS_OP_CALL_L, PCS_OP_IRQ_IN, PCS_OP_PUSH: nxt_state = ST_WR_A;
                        default:       nxt_state = ST_RD_A;
                    endcase
                end else if (reg_wr_en) begin
                    case (reg_wr_idx)
                        `PCS_IDX_PROG:  nxt_pc = {gpr_val[19:1], 1'b0};
                        `PCS_IDX_STACK: nxt_stk = {gpr_val[19:1], 1'b0};
                        `PCS_IDX_STAT:  nxt_sr = gpr_val[15:0];
                        `PCS_IDX_CONST: nxt_sr = sr_ff;
                        default:        gpr_we = 1'b1;
                    endcase
                end
            end
            ST_WR_A: begin
                if (mem_ack) begin
                    nxt_stk   = stk_ff - `PCS_WORD_STEP;
                    nxt_state = (op_ff == PCS_OP_CALL_L || op_ff == PCS_OP_IRQ_IN) ? ST_WR_B : ST_IDLE;
                    if (op_ff == PCS_OP_CALL_S) begin
                        nxt_pc = {4'h0, arg_ff[15:1], 1'b0};
                    end
                end
            end
            ST_WR_B: begin
                if (mem_ack) begin
                    nxt_stk = stk_ff - `PCS_WORD_STEP;
                    if (op_ff == PCS_OP_IRQ_IN) begin
                        nxt_state = ST_VEC;
                    end else begin
                        nxt_state = ST_IDLE;
                        nxt_pc    = {arg_ff[19:1], 1'b0};
                    end
                end
            end
            ST_VEC: begin
                if (mem_ack) begin
                    nxt_pc    = {4'h0, mem_rdata[15:1], 1'b0};
                    nxt_state = ST_IDLE;
                end
            end
            ST_RD_A: begin
                if (mem_ack) begin
                    nxt_stk   = stk_ff + `PCS_WORD_STEP;
                    nxt_hold  = mem_rdata;
                    nxt_state = ST_IDLE;
                    case (op_ff)
                        PCS_OP_EXIT_S: nxt_pc = {4'h0, mem_rdata[15:1], 1'b0};
                        PCS_OP_EXIT_L: nxt_state = ST_RD_B;
                        PCS_OP_IRQ_OUT: begin
                            nxt_sr    = {4'h0, mem_rdata[11:0]};
                            nxt_state = ST_RD_B;
                        end
                        PCS_OP_POP: begin
                            case (dst_ff)
                                `PCS_IDX_STACK: nxt_stk = {4'h0, mem_rdata[15:1], 1'b0};
                                `PCS_IDX_PROG:  nxt_pc = {4'h0, mem_rdata[15:1], 1'b0};
                                `PCS_IDX_STAT:  nxt_sr = mem_rdata;
                                `PCS_IDX_CONST: nxt_sr = sr_ff;
                                default: begin
                                    gpr_we  = 1'b1;
                                    gpr_idx = dst_ff;
                                    gpr_val = {4'h0, mem_rdata};
                                end
                            endcase
                        end
                        default: nxt_state = ST_IDLE;
                    endcase
                end
            end
            ST_RD_B: begin
                if (mem_ack) begin
                    nxt_stk   = stk_ff + `PCS_WORD_STEP;
                    nxt_state = ST_IDLE;
                    if (op_ff == PCS_OP_EXIT_L) begin
                        nxt_pc = {mem_rdata[3:0], hold_ff[15:1], 1'b0};
                    end else begin
                        nxt_pc = {hold_ff[15:12], mem_rdata[15:1], 1'b0};
                    end
                end
            end
            default: nxt_state = ST_IDLE;
        endcase
    end

    // memory request of the next step; long call return addresses go high word first, low word at lower address
    always_comb begin
        nxt_mrd   = (nxt_state == ST_RD_A) || (nxt_state == ST_RD_B) || (nxt_state == ST_VEC);
        nxt_mwr   = (nxt_state == ST_WR_A) || (nxt_state == ST_WR_B);
        nxt_addr  = nxt_stk;
        nxt_wdata = 16'h0000;
        if (nxt_mwr) begin
            nxt_addr = nxt_stk - `PCS_WORD_STEP;
        end else if (nxt_state == ST_VEC) begin
            nxt_addr = `PCS_VEC_TOP - 20'({nxt_vec, 1'b0});
        end
        if (nxt_state == ST_WR_A) begin
            case (nxt_op)
                PCS_OP_CALL_L: nxt_wdata = {12'h000, nxt_pc[19:16]};
                PCS_OP_PUSH:   nxt_wdata = nxt_arg[15:0];
                default:       nxt_wdata = nxt_pc[15:0];
            endcase
        end else if (nxt_state == ST_WR_B) begin
            if (nxt_op == PCS_OP_IRQ_IN) begin
                nxt_wdata = {nxt_pc[19:16], nxt_sr[11:0]};
            end else begin
                nxt_wdata = nxt_pc[15:0];
            end
        end
    end

    always_comb begin
        case (reg_rd_idx)
            `PCS_IDX_PROG:  nxt_rd = pc_ff;
            `PCS_IDX_STACK: nxt_rd = stk_ff;
            `PCS_IDX_STAT:  nxt_rd = {4'h0, sr_ff};
            `PCS_IDX_CONST: nxt_rd = 20'h00000;
            default:        nxt_rd = gpr_ff[reg_rd_idx];
        endcase
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            state_ff <= ST_IDLE;
            op_ff    <= PCS_OP_STEP;
            pc_ff    <= `PCS_PCNT_RST;
            stk_ff   <= `PCS_STK_RST;
            sr_ff    <= `PCS_STAT_RST;
            arg_ff   <= 20'h00000;
            dst_ff   <= 4'h0;
            vec_ff   <= '0;
            hold_ff  <= 16'h0000;
            addr_ff  <= 20'h00000;
            wdata_ff <= 16'h0000;
            mrd_ff   <= 1'b0;
            mwr_ff   <= 1'b0;
            rd_ff    <= 20'h00000;
        end else begin
            state_ff <= nxt_state;
            op_ff    <= nxt_op;
            pc_ff    <= nxt_pc;
            stk_ff   <= nxt_stk;
            sr_ff    <= nxt_sr;
            arg_ff   <= nxt_arg;
            dst_ff   <= nxt_dst;
            vec_ff   <= nxt_vec;
            hold_ff  <= nxt_hold;
            addr_ff  <= nxt_addr;
            wdata_ff <= nxt_wdata;
            mrd_ff   <= nxt_mrd;
            mwr_ff   <= nxt_mwr;
            rd_ff    <= nxt_rd;
        end
    end

    // working registers four to fifteen
    for (genvar i = 4; i < 16; i++) begin : g_gpr
        logic [19:0] nxt_gpr;
        always_comb begin
            nxt_gpr = gpr_ff[i];
            if (gpr_we && gpr_idx == 4'(i)) begin
                nxt_gpr = gpr_val;
            end
        end
        always_ff @(posedge clk_sys or negedge rstn) begin
            if (!rstn) begin
                gpr_ff[i] <= 20'h00000;
            end else begin
                gpr_ff[i] <= nxt_gpr;
            end
        end
    end

    AST_PC_EVEN: assert property (@(posedge clk_sys) disable iff (!rstn) pc_ff[0] == 1'b0)
        else $error("program counter odd");
    AST_STK_EVEN: assert property (@(posedge clk_sys) disable iff (!rstn) stk_ff[0] == 1'b0)
        else $error("stack pointer odd");
    AST_STEP: assert property (@(posedge clk_sys) disable iff (!rstn)
        cmd_ready && cmd_valid && cmd_op == PCS_OP_STEP
        |=> pc_ff == $past(pc_ff) + 20'({$past(cmd_len), 1'b0}) + 20'h00002)
        else $error("step did not advance by length");
    AST_JMP_S: assert property (@(posedge clk_sys) disable iff (!rstn)
        cmd_ready && cmd_valid && cmd_op == PCS_OP_JMP_S |=> pc_ff[19:16] == 4'h0)
        else $error("short jump left upper bits set");
    AST_JMP_L: assert property (@(posedge clk_sys) disable iff (!rstn)
        cmd_ready && cmd_valid && cmd_op == PCS_OP_JMP_L |=> pc_ff == {$past(cmd_arg[19:1]), 1'b0})
        else $error("long jump target wrong");
    AST_VEC_ADDR: assert property (@(posedge clk_sys) disable iff (!rstn)
        state_ff == ST_VEC |-> mrd_ff && addr_ff == 20'h0fffe - 20'({vec_ff, 1'b0}))
        else $error("vector address wrong");
    AST_VEC_ENTRY: assert property (@(posedge clk_sys) disable iff (!rstn)
        state_ff == ST_VEC && mem_ack |=> pc_ff[19:16] == 4'h0 && state_ff == ST_IDLE)
        else $error("handler entry outside lowest region");
    AST_IRQ_SAVE: assert property (@(posedge clk_sys) disable iff (!rstn)
        state_ff == ST_WR_B && op_ff == PCS_OP_IRQ_IN |-> mwr_ff && wdata_ff[15:12] == pc_ff[19:16])
        else $error("saved status lacks counter bits");
    AST_PUSH_PREDEC: assert property (@(posedge clk_sys) disable iff (!rstn)
        mwr_ff |-> addr_ff == stk_ff - 20'h00002)
        else $error("push not predecremented");
    AST_EXIT_S: assert property (@(posedge clk_sys) disable iff (!rstn)
        state_ff == ST_RD_A && mem_ack && op_ff == PCS_OP_EXIT_S
        |=> stk_ff == $past(stk_ff) + 20'h00002 && pc_ff == {4'h0, $past(mem_rdata[15:1]), 1'b0})
        else $error("short return wrong");
    AST_POP_STK: assert property (@(posedge clk_sys) disable iff (!rstn)
        state_ff == ST_RD_A && mem_ack && op_ff == PCS_OP_POP && dst_ff == 4'h1
        |=> stk_ff == {4'h0, $past(mem_rdata[15:1]), 1'b0})
        else $error("pop into stack pointer incremented");
    AST_WORD_WR: assert property (@(posedge clk_sys) disable iff (!rstn)
        wr_go && reg_wr_idx == 4'h0 && reg_wr_size == PCS_SZ_WORD |=> pc_ff[19:16] == 4'h0)
        else $error("word write kept upper counter bits");
endmodule

//--- hw/pcs_pkg.sv
// types shared by the program flow and stack context unit
package pcs_pkg;
    typedef enum logic [3:0] {
        PCS_OP_STEP, PCS_OP_JMP_S, PCS_OP_JMP_L, PCS_OP_CALL_S, PCS_OP_CALL_L,
        PCS_OP_EXIT_S, PCS_OP_EXIT_L, PCS_OP_IRQ_IN, PCS_OP_IRQ_OUT, PCS_OP_PUSH, PCS_OP_POP
    } pcs_op_t;
    typedef enum logic [1:0] {PCS_SZ_BYTE, PCS_SZ_WORD, PCS_SZ_AWORD} pcs_size_t;
    typedef enum logic [2:0] {ST_IDLE, ST_WR_A, ST_WR_B, ST_RD_A, ST_RD_B, ST_VEC} pcs_state_t;
endpackage

//--- verification/pcs_mem_model.sv
// word memory model that answers the core's requests after a set wait
`timescale 1ns/100ps
module pcs_mem_model (
    input  wire logic        clk_sys,   // system clock
    input  wire logic        rstn,      // async reset, active low
    input  wire logic [19:0] mem_addr,  // byte address from the core
    input  wire logic [15:0] mem_wdata, // write data
    input  wire logic        mem_rd,    // read request
    input  wire logic        mem_wr,    // write request
    input  wire logic [3:0]  wait_cyc,  // cycles before each ack
    output logic             mem_ack,   // request done this cycle
    output logic [15:0]      mem_rdata  // read data
);
    logic [15:0] words [logic [18:0]];
    int          cnt;
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            mem_ack   <= 1'b0;
            mem_rdata <= 16'h5a5a;
            cnt = 0;
        end else if ((mem_rd || mem_wr) && !mem_ack && cnt >= wait_cyc) begin
            cnt = 0;
            mem_ack <= #1 1'b1;
            if (mem_wr) begin
                words[mem_addr[19:1]] = mem_wdata;
            end
            mem_rdata <= #1 words.exists(mem_addr[19:1]) ? words[mem_addr[19:1]] : 16'h0000;
        end else begin
            if ((mem_rd || mem_wr) && !mem_ack) begin
                cnt++;
            end
            // data not valid outside the ack cycle keeps changing
            mem_ack   <= #1 1'b0;
            mem_rdata <= #1 ~mem_rdata;
        end
    end
endmodule

//--- verification/tb_cpu_pc_stack_context_unit.sv
// self-checking bench of the program flow and stack context unit
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin err_total++; \
    $display("[ERR] %s exp %h got %h", nm, ex, got); end end
module tb_cpu_pc_stack_context_unit import pcs_pkg::*;;
    typedef struct { pcs_op_t op; logic [1:0] len; logic [19:0] arg; logic [19:0] pc; } pcs_row_t;
    logic        clk_sys = 0, rstn = 0, cmd_valid = 0, reg_wr_en = 0, cmd_ready, mem_rd, mem_wr, mem_ack;
    pcs_op_t     cmd_op = PCS_OP_STEP;
    pcs_size_t   reg_wr_size = PCS_SZ_WORD;
    logic [1:0]  cmd_len = 2'h0;
    logic [19:0] cmd_arg = 20'h0, reg_wr_data = 20'h0, reg_rd_data, program_counter, stack_pointer, mem_addr;
    logic [4:0]  cmd_vec = 5'h0;
    logic [3:0]  cmd_dst = 4'h0, reg_wr_idx = 4'h0, reg_rd_idx = 4'h0, wait_cyc = 4'h0;
    logic [15:0] status_word, mem_wdata, mem_rdata;
    logic [19:0] val;
    int          err_total = 0, checks_done = 0;
    pcs_row_t    rows [6] = '{'{PCS_OP_JMP_L, 2'h0, 20'h45671, 20'h45670}, '{PCS_OP_STEP, 2'h0, 20'h0, 20'h45672},
                              '{PCS_OP_STEP, 2'h3, 20'h0, 20'h4567a}, '{PCS_OP_JMP_S, 2'h0, 20'h41234, 20'h01234},
                              '{PCS_OP_STEP, 2'h1, 20'h0, 20'h01238}, '{PCS_OP_STEP, 2'h2, 20'h0, 20'h0123e}};

    pcs_core #(.VEC_W(5)) dut (.clk_sys(clk_sys), .rstn(rstn), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .cmd_op(cmd_op), .cmd_len(cmd_len), .cmd_arg(cmd_arg), .cmd_vec(cmd_vec), .cmd_dst(cmd_dst),
        .reg_wr_en(reg_wr_en), .reg_wr_idx(reg_wr_idx), .reg_wr_size(reg_wr_size), .reg_wr_data(reg_wr_data),
        .reg_rd_idx(reg_rd_idx), .reg_rd_data(reg_rd_data), .program_counter(program_counter),
        .stack_pointer(stack_pointer), .status_word(status_word), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
    pcs_mem_model mem (.clk_sys(clk_sys), .rstn(rstn), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_rd(mem_rd), .mem_wr(mem_wr), .wait_cyc(wait_cyc), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

    initial begin
        forever #20 clk_sys = ~clk_sys;
    end

    task automatic cmd(pcs_op_t op, logic [1:0] len, logic [19:0] arg, logic [4:0] vec, logic [3:0] dst);
        int n;
        n = 0;
        @(posedge clk_sys);
        #1;
        cmd_valid = 1'b1;
        cmd_op = op;
        cmd_len = len;
        cmd_arg = arg;
        cmd_vec = vec;
        cmd_dst = dst;
        @(posedge clk_sys);
        #1;
        cmd_valid = 1'b0;
        while (cmd_ready !== 1'b1 && n < 100) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
    endtask

    task automatic wr(logic [3:0] idx, pcs_size_t sz, logic [19:0] d);
        @(posedge clk_sys);
        #1;
        reg_wr_en = 1'b1;
        reg_wr_idx = idx;
        reg_wr_size = sz;
        reg_wr_data = d;
        @(posedge clk_sys);
        #1;
        reg_wr_en = 1'b0;
    endtask

    task automatic rd(logic [3:0] idx);
        reg_rd_idx = idx;
        @(posedge clk_sys);
        #1;
        val = reg_rd_data;
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        #(40 * 5000);
        err_total++;
        finish_test();
    end

    initial begin
        repeat (16) @(posedge clk_sys);
        #1;
        `CHK("reset pc", 20'h00000, program_counter)
        `CHK("reset sp", 20'h00000, stack_pointer)
        `CHK("reset ready", 1'b1, cmd_ready)
        rstn = 1'b1;
        foreach (rows[i]) begin
            cmd(rows[i].op, rows[i].len, rows[i].arg, 5'h0, 4'h0);
            `CHK("row pc", rows[i].pc, program_counter)
        end
        $display("test flow rows done");
        wr(4'h1, PCS_SZ_WORD, 20'h30a01);
        `CHK("sp word", 20'h00a00, stack_pointer)
        wr(4'h0, PCS_SZ_WORD, 20'h54321);
        `CHK("pc word", 20'h04320, program_counter)
        wr(4'h4, PCS_SZ_BYTE, 20'hfffff);
        wr(4'hf, PCS_SZ_AWORD, 20'habcde);
        wr(4'h3, PCS_SZ_AWORD, 20'h12345);
        rd(4'h4);
        `CHK("r4 byte", 20'h000ff, val)
        rd(4'hf);
        `CHK("r15 aword", 20'habcde, val)
        rd(4'h3);
        `CHK("const reg", 20'h00000, val)
        $display("test registers done");
        wait_cyc = 4'h2;
        wr(4'h0, PCS_SZ_AWORD, 20'h92346);
        cmd(PCS_OP_CALL_L, 2'h0, 20'h78902, 5'h0, 4'h0);
        `CHK("long call hi", 16'h0009, mem.words[19'h004ff])
        `CHK("long call lo", 16'h2346, mem.words[19'h004fe])
        `CHK("long call sp", 20'h009fc, stack_pointer)
        `CHK("long call pc", 20'h78902, program_counter)
        cmd(PCS_OP_EXIT_L, 2'h0, 20'h0, 5'h0, 4'h0);
        `CHK("long ret pc", 20'h92346, program_counter)
        `CHK("long ret sp", 20'h00a00, stack_pointer)
        wait_cyc = 4'h0;
        cmd(PCS_OP_CALL_S, 2'h0, 20'h50100, 5'h0, 4'h0);
        `CHK("short call word", 16'h2346, mem.words[19'h004ff])
        `CHK("short call pc", 20'h00100, program_counter)
        cmd(PCS_OP_EXIT_S, 2'h0, 20'h0, 5'h0, 4'h0);
        `CHK("short ret pc", 20'h02346, program_counter)
        `CHK("short ret sp", 20'h00a00, stack_pointer)
        $display("test calls done");
        wr(4'h0, PCS_SZ_AWORD, 20'hc1234);
        wr(4'h2, PCS_SZ_WORD, 20'h00abc);
        wr(4'h1, PCS_SZ_WORD, 20'h0fffa);
        cmd(PCS_OP_PUSH, 2'h0, 20'h04566, 5'h0, 4'h0);
        `CHK("vector word", 16'h4566, mem.words[19'h07ffc])
        wr(4'h1, PCS_SZ_WORD, 20'h00a00);
        wait_cyc = 4'h1;
        cmd(PCS_OP_IRQ_IN, 2'h0, 20'h0, 5'h3, 4'h0);
        `CHK("irq pc word", 16'h1234, mem.words[19'h004ff])
        `CHK("irq status", 16'hcabc, mem.words[19'h004fe])
        `CHK("irq handler", 20'h04566, program_counter)
        `CHK("irq sp", 20'h009fc, stack_pointer)
        wr(4'h2, PCS_SZ_WORD, 20'h00000);
        cmd(PCS_OP_IRQ_OUT, 2'h0, 20'h0, 5'h0, 4'h0);
        `CHK("interrupt_exit pc", 20'hc1234, program_counter)
        `CHK("interrupt_exit status", 16'h0abc, status_word)
        `CHK("interrupt_exit sp", 20'h00a00, stack_pointer)
        $display("test interrupt done");
        cmd(PCS_OP_PUSH, 2'h0, 20'h00123, 5'h0, 4'h0);
        `CHK("push word", 16'h0123, mem.words[19'h004ff])
        cmd(PCS_OP_POP, 2'h0, 20'h0, 5'h0, 4'h8);
        rd(4'h8);
        `CHK("pop r8", 20'h00123, val)
        `CHK("pop sp", 20'h00a00, stack_pointer)
        cmd(PCS_OP_PUSH, 2'h0, 20'h00b00, 5'h0, 4'h0);
        cmd(PCS_OP_POP, 2'h0, 20'h0, 5'h0, 4'h1);
        `CHK("pop into sp", 20'h00b00, stack_pointer)
        $display("test stack done");
        @(posedge clk_sys);
        #1;
        rstn = 1'b0;
        @(posedge clk_sys);
        #1;
        `CHK("rerun pc", 20'h00000, program_counter)
        `CHK("rerun sp", 20'h00000, stack_pointer)
        rstn = 1'b1;
        cmd(PCS_OP_STEP, 2'h0, 20'h0, 5'h0, 4'h0);
        `CHK("rerun step", 20'h00002, program_counter)
        $display("test second reset done");
        finish_test();
    end
endmodule
